// ---- core/fault_waveform_capture_control.sv ----
`timescale 1ns/10ps
`include "fault_capture_cfg.svh"

module fault_waveform_capture_control #(
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Settings
  input wire fault_capture_pkg::capture_settings_t settings,
  // Protection indications
  input wire logic [7:0] pickup,
  input wire logic trip,
  input wire logic reclose_active,
  // External trigger sources
  input wire logic binary_trigger,
  input wire logic operator_trigger,
  // Sample stream into record memory
  input wire logic [15:0] sample_data,
  output logic mem_wr_en,
  output logic [13:0] mem_wr_addr,
  output logic [15:0] mem_wr_data,
  // Status
  output logic recording_active,
  output logic record_start_flag,
  output logic waveform_deleted,
  output logic [3:0] record_count,
  // Record directory readout
  input wire logic [2:0] dir_rd_index,
  output fault_capture_pkg::record_entry_t dir_rd_entry
);

  // Clamp a 10 ms setting into its range and convert to samples
  function automatic logic [12:0] to_samples(input logic [8:0] val, input logic [8:0] lo,
                                             input logic [8:0] hi);
    logic [8:0] c;
    c = (val < lo) ? lo : ((val > hi) ? hi : val);
    return 13'(c) * 13'(`SAMPLES_PER_10MS);
  endfunction : to_samples

  // Step a memory address backward by a span, wrapping at the depth
  function automatic logic [13:0] addr_back(input logic [13:0] a, input logic [12:0] d);
    return (a >= 14'(d)) ? 14'(a - 14'(d)) : 14'(a + `MEM_DEPTH - 14'(d));
  endfunction : addr_back

  // Step a memory address forward, wrapping at the depth
  function automatic logic [13:0] addr_next(input logic [13:0] a);
    return (a == 14'(`MEM_DEPTH - 14'h0001)) ? 14'h0000 : 14'(a + 14'h0001);
  endfunction : addr_next

  // Sequence state and the record being captured
  fault_capture_pkg::capture_state_t state;
  fault_capture_pkg::record_entry_t cur;
  logic [12:0] post_cnt, ext_cnt;
  logic is_ext, keep, criterion;
  logic sample_on, open_rec, start_rec, at_cap;
  // Sample timing and settings in samples
  logic [16:0] tick_cnt;
  logic tick;
  logic [12:0] pre_s, post_s, max_s, cap_s;
  // Trigger history
  logic pickup_any, pickup_prev, trip_prev, bin_prev, op_pending;
  logic fault_trig, ext_trig, trig;
  // Directory side
  logic dir_push, evict;
  logic [3:0] dir_count;
  fault_capture_pkg::record_entry_t dir_oldest;
  logic dir_deleted;

  // Settings converted once to sample counts
  assign pre_s = to_samples(settings.pre_time, `PRE_MIN_10MS, `PRE_MAX_10MS);
  assign post_s = to_samples(settings.post_time, `POST_MIN_10MS, `POST_MAX_10MS);
  assign max_s = to_samples(settings.max_length, `MAXLEN_MIN_10MS, `MAXLEN_MAX_10MS);
  assign cap_s = to_samples(settings.input_capture_duration, `CAPDUR_MIN_10MS,
                            `CAPDUR_MAX_10MS);

  // Sample strobe every 1.25 ms
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tick_cnt <= 17'h00000;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 17'(SAMPLE_CYCLES - 1));
      tick_cnt <= (tick_cnt == 17'(SAMPLE_CYCLES - 1)) ? 17'h00000 : tick_cnt + 17'h00001;
    end
  end

  // Trigger sources, judged at sample instants
  assign pickup_any = |pickup;
  always_comb begin
    unique case (settings.trigger_mode_select)
      fault_capture_pkg::mode_start_trip: fault_trig = trip && !trip_prev;
      default: fault_trig = pickup_any && !pickup_prev;
    endcase
  end
  assign ext_trig = (binary_trigger != bin_prev) || op_pending;
  assign trig = fault_trig || ext_trig;

  // Edge history, sampled at sample instants only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pickup_prev <= 1'b0;
      trip_prev <= 1'b0;
      bin_prev <= 1'b0; // Matches the idle level of the binary input
    end else if (tick) begin
      pickup_prev <= pickup_any;
      trip_prev <= trip;
      bin_prev <= binary_trigger;
    end
  end

  // Operator command held until the next sample instant
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      op_pending <= 1'b0;
    end else if (operator_trigger) begin
      op_pending <= 1'b1; // Set wins over the clear below
    end else if (tick) begin
      op_pending <= 1'b0;
    end
  end

  // Storage criterion for the open record
  always_comb begin
    if (is_ext) begin
      criterion = settings.capture_infinite ? binary_trigger : (ext_cnt < cap_s);
    end else if (settings.trigger_mode_select == fault_capture_pkg::mode_start_trip) begin
      criterion = trip;
    end else begin
      criterion = pickup_any;
    end
    if (!is_ext && settings.scope == fault_capture_pkg::scope_system_fault) begin
      criterion = criterion || reclose_active;
    end
  end

  // Decisions shared by the sequence, the record fields and the status outputs
  assign sample_on = tick && settings.capture_enable;
  assign open_rec = (state == fault_capture_pkg::st_run) ||
                    (state == fault_capture_pkg::st_post);
  assign start_rec = (state == fault_capture_pkg::st_idle) && sample_on && trig;
  assign at_cap = (cur.length + 13'h0001 >= max_s);

  // Capture sequence; triggers are only looked at while idle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= fault_capture_pkg::st_idle;
    end else begin
      unique case (state)
        fault_capture_pkg::st_idle: begin
          if (start_rec) begin
            state <= fault_capture_pkg::st_run;
          end
        end
        fault_capture_pkg::st_run, fault_capture_pkg::st_post: begin
          if (!settings.capture_enable) begin
            state <= fault_capture_pkg::st_idle;
          end else if (tick) begin
            if (at_cap) begin
              state <= fault_capture_pkg::st_close;
            end else if (criterion) begin
              state <= fault_capture_pkg::st_run; // Fault renewed during post time
            end else if (state == fault_capture_pkg::st_run) begin
              state <= fault_capture_pkg::st_post;
            end else if (post_cnt >= post_s) begin
              state <= fault_capture_pkg::st_close;
            end
          end
        end
        fault_capture_pkg::st_close: begin
          state <= fault_capture_pkg::st_idle;
        end
      endcase
    end
  end

  // Record descriptor: start reaches back by the pre time, length counts samples
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur <= '0;
    end else if (start_rec) begin
      cur.start <= addr_back(mem_wr_addr, pre_s);
      cur.length <= pre_s + 13'h0001;
    end else if (open_rec && sample_on) begin
      cur.length <= cur.length + 13'h0001;
    end
  end

  // Post time counter, restarted whenever the criterion comes back
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      post_cnt <= 13'h0000;
    end else if (open_rec && sample_on && !at_cap) begin
      if (criterion) begin
        post_cnt <= 13'h0000;
      end else if (state == fault_capture_pkg::st_run) begin
        post_cnt <= 13'h0001;
      end else if (post_cnt < post_s) begin
        post_cnt <= post_cnt + 13'h0001;
      end
    end
  end

  // Input capture duration count from the trigger instant
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_cnt <= 13'h0000;
    end else if (start_rec) begin
      ext_cnt <= 13'h0000;
    end else if (open_rec && sample_on) begin
      ext_cnt <= ext_cnt + 13'h0001;
    end
  end

  // Origin of the open record and its keep decision
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      is_ext <= 1'b0;
      keep <= 1'b0;
    end else if (start_rec) begin
      is_ext <= !fault_trig;
      keep <= !fault_trig ||
              settings.trigger_mode_select != fault_capture_pkg::mode_save_trip;
    end else if (open_rec && sample_on && trip) begin
      keep <= 1'b1;
    end
  end

  // Close hands a kept record to the directory; oldest data is evicted on overwrite
  assign dir_push = (state == fault_capture_pkg::st_close) && keep;
  assign evict = sample_on && (dir_count != 4'h0) &&
                 (addr_next(mem_wr_addr) == dir_oldest.start);

  record_directory u_dir (
    .clk_sys(clk_sys),
    .reset(reset),
    .push(dir_push),
    .push_entry(cur),
    .pop_oldest(evict),
    .count(dir_count),
    .oldest(dir_oldest),
    .deleted(dir_deleted),
    .rd_index(dir_rd_index),
    .rd_entry(dir_rd_entry)
  );

  // Revolving sample write into record memory
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_wr_en <= 1'b0;
      mem_wr_addr <= 14'h0000;
      mem_wr_data <= 16'h0000;
    end else begin
      mem_wr_en <= sample_on;
      if (sample_on) begin
        mem_wr_data <= sample_data;
        mem_wr_addr <= addr_next(mem_wr_addr);
      end
    end
  end

  // Record status outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      recording_active <= 1'b0;
      record_start_flag <= 1'b0;
    end else begin
      recording_active <= open_rec;
      record_start_flag <= start_rec;
    end
  end

  // Directory status outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      waveform_deleted <= 1'b0;
      record_count <= 4'h0;
    end else begin
      waveform_deleted <= dir_deleted;
      record_count <= dir_count;
    end
  end

endmodule : fault_waveform_capture_control

// ---- core/fault_capture_cfg.svh ----
`ifndef FAULT_CAPTURE_CFG_SVH
`define FAULT_CAPTURE_CFG_SVH

// Clock and sample timing
`define CLK_PERIOD_NS 10
`define SAMPLE_PERIOD_NS 1250000
`define SAMPLE_CYCLES (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)
`define SAMPLES_PER_10MS 8

// Setting ranges in units of 10 ms
`define PRE_MIN_10MS 9'h005
`define PRE_MAX_10MS 9'h032
`define PRE_DEF_10MS 9'h019
`define POST_MIN_10MS 9'h005
`define POST_MAX_10MS 9'h032
`define POST_DEF_10MS 9'h00A
`define MAXLEN_MIN_10MS 9'h01E
`define MAXLEN_MAX_10MS 9'h1F4
`define MAXLEN_DEF_10MS 9'h0C8
`define CAPDUR_MIN_10MS 9'h00A
`define CAPDUR_MAX_10MS 9'h1F4
`define CAPDUR_DEF_10MS 9'h032

// Record memory: 20 s of samples, at most 8 records
`define MEM_DEPTH 14'h3E80
`define MEM_AW 14
`define DIR_DEPTH 8
`define DIR_IW 3
`define LEN_W 13

`endif

// ---- core/fault_capture_pkg.sv ----
package fault_capture_pkg;

  // Capture sequence, Gray coded along idle-run-post-close
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_run = 2'b01,
    st_post = 2'b11,
    st_close = 2'b10
  } capture_state_t;

  typedef enum logic [1:0] {
    mode_save_pickup = 2'b00,
    mode_save_trip = 2'b01,
    mode_start_trip = 2'b10
  } trigger_mode_t;

  typedef enum logic {
    scope_fault_event = 1'b0,
    scope_system_fault = 1'b1
  } capture_scope_t;

  // Operator settings, times in units of 10 ms
  typedef struct packed {
    logic capture_enable;
    trigger_mode_t trigger_mode_select;
    capture_scope_t scope;
    logic [8:0] pre_time;
    logic [8:0] post_time;
    logic [8:0] max_length;
    logic [8:0] input_capture_duration;
    logic capture_infinite;
  } capture_settings_t;

  // One stored record: first sample address and length in samples
  typedef struct packed {
    logic [13:0] start;
    logic [12:0] length;
  } record_entry_t;

endpackage : fault_capture_pkg

// ---- core/record_directory.sv ----
`timescale 1ns/10ps
`include "fault_capture_cfg.svh"

module record_directory (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Update
  input wire logic push,
  input wire fault_capture_pkg::record_entry_t push_entry,
  input wire logic pop_oldest,
  // State
  output logic [3:0] count,
  output fault_capture_pkg::record_entry_t oldest,
  output logic deleted,
  // Read port, index 0 is the oldest record
  input wire logic [2:0] rd_index,
  output fault_capture_pkg::record_entry_t rd_entry
);

  fault_capture_pkg::record_entry_t entry [`DIR_DEPTH];
  logic [2:0] head;
  logic full;
  logic do_pop;

  assign full = (count == 4'(`DIR_DEPTH));
  // A push into a full directory displaces the oldest record
  assign do_pop = (pop_oldest || (push && full)) && (count != 4'h0);
  assign oldest = entry[head];

  // Ring of entries written at head plus count
  always_ff @(posedge clk_sys) begin
    if (push) begin
      entry[3'(head + count[2:0])] <= push_entry;
    end
  end

  // Occupancy and oldest pointer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      head <= 3'h0;
      count <= 4'h0;
    end else begin
      if (do_pop) begin
        head <= head + 3'h1;
      end
      count <= count + 4'(push) - 4'(do_pop);
    end
  end

  // Deletion event and registered read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      deleted <= 1'b0;
      rd_entry <= '0;
    end else begin
      deleted <= do_pop;
      rd_entry <= (3'(rd_index) < count[2:0] || full) ? entry[3'(head + rd_index)] : '0;
    end
  end

endmodule : record_directory

// ---- verification/fault_capture_checker.sv ----
`timescale 1ns/10ps
module fault_capture_checker #(
  parameter int SAMPLE_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Watched ports
  input wire fault_capture_pkg::capture_settings_t settings,
  input wire logic [15:0] sample_data,
  input wire logic mem_wr_en,
  input wire logic [13:0] mem_wr_addr,
  input wire logic [15:0] mem_wr_data,
  input wire logic recording_active,
  input wire logic record_start_flag,
  input wire logic waveform_deleted,
  input wire logic [3:0] record_count
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic seen_wr;
  logic [13:0] last_addr;
  logic [13:0] next_addr;
  // Track the previous write to predict the next address
  always_ff @(posedge clk_sys) begin
    if (reset) seen_wr <= 1'b0;
    else if (mem_wr_en) seen_wr <= 1'b1;
  end
  always_ff @(posedge clk_sys) begin
    if (mem_wr_en) last_addr <= mem_wr_addr;
  end
  // Revolving buffer wraps after the last sample slot
  assign next_addr = (last_addr == 14'h3E7F) ? 14'h0000 : last_addr + 14'h0001;
  sequence s_opened;
    record_start_flag ##1 recording_active;
  endsequence
  a_flag_pulse: assert property (record_start_flag |=> !record_start_flag)
    else $error("start flag longer than one cycle");
  a_flag_opens: assert property (record_start_flag |-> s_opened)
    else $error("record did not go active");
  a_off_no_start: assert property (!settings.capture_enable |=> !record_start_flag)
    else $error("start while disabled");
  a_off_no_write: assert property (!settings.capture_enable |=> !mem_wr_en)
    else $error("write while disabled");
  a_no_retrigger: assert property (recording_active |-> !record_start_flag)
    else $error("second record opened");
  a_wr_data: assert property (mem_wr_en |-> mem_wr_data == $past(sample_data))
    else $error("stored sample wrong");
  a_wr_addr: assert property (mem_wr_en && seen_wr |-> mem_wr_addr == next_addr)
    else $error("write address not revolving");
  a_count_limit: assert property (record_count <= 4'h8)
    else $error("more than eight records");
  a_count_step: assert property (record_count > $past(record_count)
    |-> record_count == $past(record_count) + 4'h1)
    else $error("record count jumped");
endmodule : fault_capture_checker

bind fault_waveform_capture_control fault_capture_checker #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES)
) chk (
  .clk_sys(clk_sys),
  .reset(reset),
  .settings(settings),
  .sample_data(sample_data),
  .mem_wr_en(mem_wr_en),
  .mem_wr_addr(mem_wr_addr),
  .mem_wr_data(mem_wr_data),
  .recording_active(recording_active),
  .record_start_flag(record_start_flag),
  .waveform_deleted(waveform_deleted),
  .record_count(record_count)
);

// ---- verification/protection_source_model.sv ----
`timescale 1ns/10ps
module protection_source_model (
  // Clock
  input wire logic clk_sys,
  // Scenario commands
  input wire logic fault_cmd,
  input wire logic trip_cmd,
  input wire logic reclose_cmd,
  input wire logic bin_cmd,
  // Protection side
  output logic [7:0] pickup,
  output logic trip,
  output logic reclose_active,
  output logic binary_trigger,
  output logic [15:0] sample_data
);
  initial begin
    pickup = 8'h00;
    trip = 1'b0;
    reclose_active = 1'b0;
    binary_trigger = 1'b0;
    sample_data = 16'h0000;
  end
  // Indications follow the commands off the sampling edge
  always @(negedge clk_sys) begin
    pickup <= fault_cmd ? 8'h24 : 8'h00;
    trip <= trip_cmd;
    reclose_active <= reclose_cmd;
    binary_trigger <= bin_cmd;
    sample_data <= {sample_data[14:0], ~sample_data[15]};
  end
endmodule : protection_source_model

// ---- verification/fault_waveform_capture_control_tb.sv ----
`timescale 1ns/10ps
module fault_waveform_capture_control_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  fault_capture_pkg::capture_settings_t settings = '0;
  logic [7:0] pickup;
  logic trip, reclose_active, binary_trigger, mem_wr_en;
  logic operator_trigger = 1'b0;
  logic fault_cmd = 1'b0, trip_cmd = 1'b0, reclose_cmd = 1'b0, bin_cmd = 1'b0;
  logic [15:0] sample_data, mem_wr_data;
  logic [13:0] mem_wr_addr;
  logic recording_active, record_start_flag, waveform_deleted;
  logic [3:0] record_count;
  logic [2:0] dir_rd_index = 3'h0;
  fault_capture_pkg::record_entry_t dir_rd_entry;
  logic [12:0] len;
  logic [13:0] flag_addr;
  int num_errors = 0, n_checks = 0, flags = 0, dels = 0;

  fault_waveform_capture_control #(.SAMPLE_CYCLES(4)) uut (.*);
  protection_source_model src (.*);

  always #5 clk_sys = ~clk_sys;
  // Count start and deletion pulses once outputs settle
  always @(posedge clk_sys) begin
    #1;
    if (record_start_flag === 1'b1) begin
      flags++;
      flag_addr = mem_wr_addr;
    end
    if (waveform_deleted === 1'b1) dels++;
  end

  task automatic run(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : run
  task automatic check(input logic [12:0] seen, input logic [12:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s seen %0d exp %0d", $time, what, seen, exp);
    end
  endtask : check
  task automatic fin(input string name);
    $display("test %s done", name);
    flags = 0;
    dels = 0;
  endtask : fin
  task automatic entry_len(input logic [2:0] idx);
    dir_rd_index = idx;
    run(2);
    len = dir_rd_entry.length;
  endtask : entry_len
  task automatic op();
    operator_trigger = 1'b1;
    run(1);
    operator_trigger = 1'b0;
  endtask : op
  task automatic pulse(input logic f, input logic t);
    fault_cmd <= f;
    trip_cmd <= t;
    run(20);
    fault_cmd <= 1'b0;
    trip_cmd <= 1'b0;
    run(300);
  endtask : pulse
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Watchdog well beyond the expected run of about 9000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    $display("unexpected at %0t: timeout", $time);
    test_done();
  end

  initial begin
    settings.pre_time = 9'h005;
    settings.post_time = 9'h005;
    settings.max_length = 9'h01E;
    settings.input_capture_duration = 9'h00A;
    run(6);
    reset = 1'b0;
    // Disabled capture ignores a fault
    pulse(1'b1, 1'b0);
    check(13'(flags), 13'h0, "off flags");
    check(13'(record_count), 13'h0, "off count");
    fin("disabled");
    settings.capture_enable = 1'b1;
    run(200);
    // Short pickup with an operator retrigger inside it
    fault_cmd <= 1'b1;
    run(20);
    op();
    pulse(1'b0, 1'b0);
    check(13'(flags), 13'h1, "pickup flags");
    check(13'(record_count), 13'h1, "pickup count");
    entry_len(3'h0);
    check(13'(len >= 80 && len <= 92), 13'h1, "pickup length");
    check(13'(dir_rd_entry.start == flag_addr - 14'h0029), 13'h1, "pickup start");
    entry_len(3'h1);
    check(13'(dir_rd_entry == '0), 13'h1, "empty entry");
    fin("pickup");
    // Long pickup is cut at the record cap
    fault_cmd <= 1'b1;
    run(1500);
    check(13'(recording_active), 13'h0, "cap active");
    entry_len(3'h1);
    check(len, 13'h0F0, "cap length");
    fault_cmd <= 1'b0;
    run(20);
    fin("cap");
    // Save on trip keeps only a tripped fault
    settings.trigger_mode_select = fault_capture_pkg::mode_save_trip;
    pulse(1'b1, 1'b0);
    check(13'(record_count), 13'h2, "no trip kept");
    pulse(1'b1, 1'b1);
    check(13'(record_count), 13'h3, "trip kept");
    fin("save_trip");
    // Start on trip ignores a bare pickup
    settings.trigger_mode_select = fault_capture_pkg::mode_start_trip;
    pulse(1'b1, 1'b0);
    check(13'(flags), 13'h0, "pickup only");
    pulse(1'b0, 1'b1);
    check(13'(record_count), 13'h4, "trip start");
    fin("start_trip");
    // External records fill the directory and displace the oldest
    settings.trigger_mode_select = fault_capture_pkg::mode_save_pickup;
    for (int i = 0; i < 5; i++) begin
      if (i == 0) bin_cmd <= 1'b1;
      else op();
      run(20);
      bin_cmd <= 1'b0;
      run(730);
    end
    check(13'(flags), 13'h5, "ext flags");
    check(13'(record_count), 13'h8, "full count");
    check(13'(dels), 13'h1, "deleted");
    entry_len(3'h7);
    check(13'(len >= 158 && len <= 164), 13'h1, "ext length");
    fin("external");
    // System scope spans the reclose dead time
    settings.scope = fault_capture_pkg::scope_system_fault;
    fault_cmd <= 1'b1;
    run(20);
    fault_cmd <= 1'b0;
    reclose_cmd <= 1'b1;
    run(250);
    pulse(1'b1, 1'b0);
    reclose_cmd <= 1'b0;
    run(300);
    check(13'(flags), 13'h1, "system flags");
    fin("system");
    // Infinite duration follows the binary input
    settings.scope = fault_capture_pkg::scope_fault_event;
    settings.capture_infinite = 1'b1;
    bin_cmd <= 1'b1;
    run(400);
    check(13'(recording_active), 13'h1, "held active");
    bin_cmd <= 1'b0;
    run(400);
    check(13'(flags), 13'h1, "infinite flags");
    entry_len(3'h7);
    check(13'(len >= 176 && len <= 186), 13'h1, "inf length");
    fin("infinite");
    test_done();
  end
endmodule : fault_waveform_capture_control_tb
